/* File: shared/wwdt_consts.svh */
`ifndef WWDT_CONSTS_SVH
`define WWDT_CONSTS_SVH
// Register indices (printed offsets are not word multiples: byte addr = 4*idx)
`define WWDT_IDX_CTRL0   12'hECD
`define WWDT_IDX_CTRL1   12'hECE
`define WWDT_IDX_PSLO    12'hECF
`define WWDT_IDX_PSHI    12'hED0
`define WWDT_IDX_TMR     12'hED1
`define WWDT_IDX_INTST   12'hED2
`define WWDT_IDX_INTMSK  12'hED3
// Field values
`define WWDT_PS_OPEN     5'h1F
`define WWDT_PS_DEFAULT  5'h0B
`define WWDT_PS_MAXCODE  5'h12
`define WWDT_CS_OPEN     3'h7
`define WWDT_CS_RESET    3'h0
`define WWDT_CS_LF       3'h0
`define WWDT_CS_MF       3'h1
`define WWDT_WIN_OPEN    3'h7
`define WWDT_MODE_SOFT   2'h1
`define WWDT_PS_MINDIV   5'h05
// AXI responses
`define WWDT_RESP_OKAY   2'h0
`define WWDT_RESP_SLVERR 2'h2
// Interrupt status bit positions
`define WWDT_EV_TIMEOUT  0
`define WWDT_EV_VIOL     1
`define WWDT_EV_WAKE     2
`endif

/* File: shared/wwdt_pkg.sv */
package wwdt_pkg;
  typedef enum logic [1:0] {
    WWDT_OFF_ALWAYS, WWDT_SOFT, WWDT_ON_AWAKE, WWDT_ON_ALWAYS
  } wwdt_mode_t;
  typedef enum {WWDT_B_IDLE, WWDT_B_RESP} wwdt_bus_st_t;
endpackage

/* File: logic/wwdt_tick_sync.sv */
`timescale 1ns/1ns
`default_nettype none
// Brings one watchdog oscillator edge into the mclk domain
module wwdt_tick_sync (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic ce,
  input  wire logic osc_in,
  output logic      tick
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  // Two flops, then a third for edge detect; s1_r feeds only s2_r
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else if (ce) begin
      s1_r <= osc_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign tick = ce & s2_r & ~s3_r;
endmodule // wwdt_tick_sync
`default_nettype wire

/* File: logic/wwdt_counter.sv */
`timescale 1ns/1ns
`default_nettype none
`include "wwdt_consts.svh"
// 18-bit prescaler plus 5-bit window counter
module wwdt_counter #(
  parameter int PS_W = 18
) (
  input  wire logic            mclk,
  input  wire logic            sys_rst,
  input  wire logic            ce,
  input  wire logic            tick,
  input  wire logic            clr,
  input  wire logic [4:0]      ratio,
  output logic [PS_W-1:0]      ps_cnt,
  output logic [4:0]           win_cnt,
  output logic                 timeout
);
  logic [4:0]      shift;
  logic [PS_W-1:0] ps_top;
  logic            ps_wrap;
  // Reserved codes act as the minimum interval
  assign shift  = (ratio > `WWDT_PS_MAXCODE) ? 5'h00 : ratio;
  // Prescaler period 2^code ticks; 32 window steps give 2^(5+code) in all
  assign ps_top = PS_W'((64'h1 << shift) - 64'h1);
  assign ps_wrap = tick & (ps_cnt == ps_top);
  assign timeout = ps_wrap & (win_cnt == 5'h1F);
  // Prescaler and window counter, cleared by any clear source
  always_ff @(posedge mclk) begin
    if (sys_rst | (ce & clr)) begin
      ps_cnt  <= '0;
      win_cnt <= 5'h00;
    end else if (ce & tick) begin
      ps_cnt  <= ps_wrap ? '0 : ps_cnt + 1'b1;
      if (ps_wrap) win_cnt <= win_cnt + 5'h01;
    end
  end
endmodule // wwdt_counter
`default_nettype wire

/* File: logic/wwdt_top.sv */
// Behaviour
// - Prescale code 0 divides by 32, each step doubles, up to code 18.
// - Prescale codes 19..31 behave as minimum interval.
// - Prescale resets to 01011 if config is 11111, else config; enable 0.
// - Prescale field read-only unless config prescale setting is 11111.
// - Soft enable bit controls watchdog only in enable mode 01.
// - Clock select 000 low-frequency, 001 medium-frequency, others reserved.
// - Clock select resets 000 if config clock 111, else config; writable only if 111.
// - Window field resets from config, writable only if config is 111.
// - Window code 111 opens 100 percent, each step down 12.5 percent less.
// - Window open while counter >= 4*(7-code).
// - Timer register bit 2 reads the armed state.
// - 18-bit prescaler count readable across low, high, timer bits 1:0.
// - Count and timer registers read-only, reset zero, writes ignored.
// - Intervals assume the 31 kHz low-frequency clock; code 0 about 1 ms.
// - Clear with window closed is a violation, resets like a time-out.
// - Clear needs prior read of control zero; unarmed clear is violation.
// - Counters clear on control write, reset, clear, sleep, wake, disable.
// - Time-out in sleep wakes the device instead of resetting.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "wwdt_consts.svh"
module wwdt_top
  import wwdt_pkg::*;
#(
  parameter int          PS_W  = 18,
  parameter logic [11:0] ADDR_W_IDX = 12'h000
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  // AXI4-Lite slave
  input  wire logic [13:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [13:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Configuration word settings (static straps)
  input  wire logic [1:0]  config_enable_mode,
  input  wire logic [4:0]  config_prescale_setting,
  input  wire logic [2:0]  config_clock_setting,
  input  wire logic [2:0]  config_opening_setting,
  // Core and power-state events (same clock domain)
  input  wire logic        clear_instruction,
  input  wire logic        sleep_enter,
  input  wire logic        sleep_active,
  input  wire logic        wake_by_irq,
  // Oscillator pins (asynchronous)
  input  wire logic        low_freq_oscillator,
  input  wire logic        medium_freq_oscillator,
  // System reset and wake logic
  output logic             wdog_reset,
  output logic             violation_flag,
  output logic             wake_event,
  output logic             wdog_running,
  output logic             irq
);
  logic [4:0] ratio_r;
  logic       soft_en_r;
  logic [2:0] clksel_r;
  logic [2:0] window_r;
  logic       armed_r;
  logic       cfg_load_r;
  logic [2:0] ist_r;
  logic [2:0] imsk_r;
  logic       aw_got_r;
  logic       w_got_r;
  logic [11:0] aw_idx_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic [PS_W-1:0] ps_cnt;
  logic [4:0]  win_cnt;
  logic        timeout;
  logic        tick_lf;
  logic        tick_mf;

  // Bus decode
  wire  [11:0] ar_idx   = s_axi_araddr[13:2];
  wire         do_wr    = aw_got_r & w_got_r & ~s_axi_bvalid;
  wire         do_rd    = s_axi_arvalid & s_axi_arready;
  wire         wr_ctrl0 = do_wr & (aw_idx_r == `WWDT_IDX_CTRL0) & wstrb_r[0];
  wire         wr_ctrl1 = do_wr & (aw_idx_r == `WWDT_IDX_CTRL1) & wstrb_r[0];
  wire         wr_msk   = do_wr & (aw_idx_r == `WWDT_IDX_INTMSK) & wstrb_r[0];
  wire         rd_ctrl0 = do_rd & (ar_idx == `WWDT_IDX_CTRL0);
  wire         rd_ist   = do_rd & (ar_idx == `WWDT_IDX_INTST);
  wire         wr_known = (aw_idx_r >= `WWDT_IDX_CTRL0) &
                          (aw_idx_r <= `WWDT_IDX_INTMSK);
  wire         rd_known = (ar_idx >= `WWDT_IDX_CTRL0) &
                          (ar_idx <= `WWDT_IDX_INTMSK);

  // Writability from configuration straps
  wire ps_wr_ok  = (config_prescale_setting == `WWDT_PS_OPEN);
  wire cs_wr_ok  = (config_clock_setting == `WWDT_CS_OPEN);
  wire win_wr_ok = (config_opening_setting == `WWDT_WIN_OPEN);

  // Operating mode decode
  wire [1:0] mode_bits = config_enable_mode;
  wire       enabled   = (mode_bits == 2'(WWDT_ON_ALWAYS)) |
                         ((mode_bits == 2'(WWDT_ON_AWAKE)) & ~sleep_active) |
                         ((mode_bits == `WWDT_MODE_SOFT) & soft_en_r);
  logic enabled_q_r;
  wire  disable_ev = enabled_q_r & ~enabled;

  // Clock source: code 0 low-frequency, 1 medium; reserved codes pick none
  wire [2:0] eff_cs = cs_wr_ok ? clksel_r : config_clock_setting;
  wire tick_sel = (eff_cs == `WWDT_CS_LF) ? tick_lf :
                  (eff_cs == `WWDT_CS_MF) ? tick_mf : 1'b0;
  wire tick_run = tick_sel & enabled;

  // Window: open at or above 4*(7-code)
  wire [2:0] eff_win   = win_wr_ok ? window_r : config_opening_setting;
  wire [4:0] open_from = {3'h7 - eff_win, 2'b00};
  wire       win_open  = (win_cnt >= open_from);

  // Clear classification: armed and in window, else violation
  wire clr_ok   = enabled & clear_instruction & armed_r & win_open;
  wire clr_viol = enabled & clear_instruction & ~clr_ok;

  // Time-out in sleep wakes instead of reset
  wire to_sleep = timeout & sleep_active;
  wire to_reset = timeout & ~sleep_active;

  // All sources that clear the counters
  wire ctr_clr = wr_ctrl0 | wr_ctrl1 | clr_ok | sleep_enter |
                 wake_by_irq | disable_ev | ~enabled;

  wwdt_tick_sync u_sync_lf (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .osc_in  (low_freq_oscillator),
    .tick    (tick_lf)
  );
  wwdt_tick_sync u_sync_mf (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .osc_in  (medium_freq_oscillator),
    .tick    (tick_mf)
  );
  wwdt_counter #(.PS_W(PS_W)) u_cnt (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .tick    (tick_run),
    .clr     (ctr_clr),
    .ratio   (ratio_r),
    .ps_cnt  (ps_cnt),
    .win_cnt (win_cnt),
    .timeout (timeout)
  );

  // Control registers; prescale and window reset values caught one cycle after release
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ratio_r    <= `WWDT_PS_DEFAULT;
      soft_en_r  <= 1'b0;
      clksel_r   <= `WWDT_CS_RESET;
      window_r   <= `WWDT_WIN_OPEN;
      cfg_load_r <= 1'b1;
    end else if (ce) begin
      cfg_load_r <= 1'b0;
      if (cfg_load_r) begin
        ratio_r  <= ps_wr_ok ? `WWDT_PS_DEFAULT
                             : config_prescale_setting;
        window_r <= config_opening_setting;
      end else begin
        if (wr_ctrl0 & ps_wr_ok) ratio_r <= wdata_r[5:1];
        if (wr_ctrl0) soft_en_r <= wdata_r[0];
        if (wr_ctrl1 & cs_wr_ok) clksel_r <= wdata_r[6:4];
        if (wr_ctrl1 & win_wr_ok) window_r <= wdata_r[2:0];
      end
    end
  end

  // Arming: set by reading control zero, spent by a clear instruction or any counter clear; a read in the same cycle wins
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      armed_r     <= 1'b0;
      enabled_q_r <= 1'b0;
    end else if (ce) begin
      enabled_q_r <= enabled;
      if (rd_ctrl0) armed_r <= 1'b1;
      else if (clear_instruction | ctr_clr) armed_r <= 1'b0;
    end
  end

  // Reset and wake outputs: one-cycle pulses; wdog_running is enabled, registered
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wdog_reset     <= 1'b0;
      violation_flag <= 1'b0;
      wake_event     <= 1'b0;
      wdog_running   <= 1'b0;
    end else if (ce) begin
      wdog_reset     <= to_reset | clr_viol;
      violation_flag <= clr_viol;
      wake_event     <= to_sleep;
      wdog_running   <= enabled;
    end
  end

  // Sticky interrupt status; set wins over read-clear
  wire [2:0] ev_set = {to_sleep, clr_viol, to_reset};
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ist_r  <= 3'h0;
      imsk_r <= 3'h0;
    end else if (ce) begin
      ist_r <= (rd_ist ? 3'h0 : ist_r) | ev_set;
      if (wr_msk) imsk_r <= wdata_r[2:0];
    end
  end
  assign irq = |(ist_r & imsk_r);

  // Read data mux; count and timer registers are read-only
  wire [7:0] tmr_val = {win_cnt, armed_r, ps_cnt[17:16]};
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    case (ar_idx)
      `WWDT_IDX_CTRL0:  rd_val = {26'h0, ratio_r, soft_en_r};
      `WWDT_IDX_CTRL1:  rd_val = {25'h0, eff_cs, 1'b0, eff_win};
      `WWDT_IDX_PSLO:   rd_val = {24'h0, ps_cnt[7:0]};
      `WWDT_IDX_PSHI:   rd_val = {24'h0, ps_cnt[15:8]};
      `WWDT_IDX_TMR:    rd_val = {24'h0, tmr_val};
      `WWDT_IDX_INTST:  rd_val = {29'h0, ist_r};
      `WWDT_IDX_INTMSK: rd_val = {29'h0, imsk_r};
      default:          rd_val = 32'h0000_0000;
    endcase
  end

  // Write channel capture: address and data in either order
  assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got_r & ~s_axi_bvalid;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      aw_got_r     <= 1'b0;
      w_got_r      <= 1'b0;
      aw_idx_r     <= 12'h000;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `WWDT_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_idx_r <= s_axi_awaddr[13:2];
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `WWDT_RESP_OKAY : `WWDT_RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one read under way; answer the cycle after acceptance
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `WWDT_RESP_OKAY;
    end else if (ce) begin
      if (do_rd) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_known ? `WWDT_RESP_OKAY : `WWDT_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Unarmed or closed-window clear must give a violation and a reset
  a_viol_cause: assert property (
    @(posedge mclk) disable iff (sys_rst)
    ce & enabled & clear_instruction & (~armed_r | ~win_open)
      |=> wdog_reset & violation_flag)
    else $error("clear outside window did not reset");
  // Good clear without a time-out never flags a violation
  a_good_clear: assert property (
    @(posedge mclk) disable iff (sys_rst)
    ce & clr_ok & ~timeout |=> ~violation_flag)
    else $error("armed clear flagged as violation");
  // Sleep time-out wakes and does not reset
  a_sleep_wake: assert property (
    @(posedge mclk) disable iff (sys_rst)
    ce & timeout & sleep_active & ~clr_viol |=> wake_event & ~wdog_reset)
    else $error("sleep time-out reset the device");
  // Control write clears the window counter
  a_wr_clears: assert property (
    @(posedge mclk) disable iff (sys_rst)
    ce & (wr_ctrl0 | wr_ctrl1) |=> (win_cnt == 5'h00))
    else $error("control write did not clear counter");
  // Locked prescale field holds
  a_ps_locked: assert property (
    @(posedge mclk) disable iff (sys_rst)
    ce & ~ps_wr_ok & ~cfg_load_r |=> $stable(ratio_r))
    else $error("locked prescale changed");
  // Window opens exactly at 4*(7-code)
  a_win_edge: assert property (
    @(posedge mclk) disable iff (sys_rst)
    win_open == ({3'h0, win_cnt} >= (8'h1C - {3'h0, eff_win, 2'b00})))
    else $error("window edge wrong");
  // Mode 01 with enable cleared keeps the counter idle
  a_soft_off: assert property (
    @(posedge mclk) disable iff (sys_rst)
    ce & (mode_bits == `WWDT_MODE_SOFT) & ~soft_en_r |=> (win_cnt == 5'h00))
    else $error("soft-disabled watchdog counted");
  // Reading control zero arms the watchdog
  a_armed_bit: assert property (
    @(posedge mclk) disable iff (sys_rst)
    ce & rd_ctrl0 |=> armed_r)
    else $error("read of control zero did not arm");
endmodule // wwdt_top
`default_nettype wire

/* File: dv/wwdt_far_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Oscillator sources and the system reset and wake logic beyond the watchdog
module wwdt_far_model #(
  parameter int LF_HALF_NS = 156,
  parameter int MF_HALF_NS = 154
) (
  input  wire logic mclk,
  input  wire logic wdog_reset,
  input  wire logic wake_event,
  output logic      osc_lf,
  output logic      osc_mf,
  output int        n_resets,
  output int        n_wakes
);
  int n_resets_r = 0;
  int n_wakes_r  = 0;

  // Sources run far above their real rate so that time-outs stay short
  initial begin
    osc_lf = 1'b0;
    forever #(LF_HALF_NS) osc_lf = ~osc_lf;
  end

  // Medium source a little faster, as the two nominal rates differ
  initial begin
    osc_mf = 1'b0;
    forever #(MF_HALF_NS) osc_mf = ~osc_mf;
  end

  // Reset and wake requests are counted only; the bench owns sys_rst
  always @(posedge mclk) begin
    if (wdog_reset === 1'b1) n_resets_r <= n_resets_r + 1;
    if (wake_event === 1'b1) n_wakes_r <= n_wakes_r + 1;
  end
  assign n_resets = n_resets_r;
  assign n_wakes  = n_wakes_r;
endmodule // wwdt_far_model
`default_nettype wire

/* File: dv/windowed_watchdog_regs_counter_test.sv */
`timescale 1ns/1ns
`default_nettype none
`include "wwdt_consts.svh"
module windowed_watchdog_regs_counter_test;
  localparam int HALF = 156;
  logic        mclk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [13:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [1:0]  bresp, rresp, r, cfg_mode;
  logic [4:0]  cfg_ps;
  logic [2:0]  cfg_cs, cfg_win;
  logic        clr_i, slp_en, slp_act, wake_i, osc_lf, osc_mf;
  logic        wd_rst, viol, wake_ev, running, irq;
  int          n_fail, compares, n_resets, n_wakes, cyc, base;

  wwdt_top wwdt_top_i (.mclk(mclk), .sys_rst(sys_rst), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .config_enable_mode(cfg_mode), .config_prescale_setting(cfg_ps),
    .config_clock_setting(cfg_cs), .config_opening_setting(cfg_win),
    .clear_instruction(clr_i), .sleep_enter(slp_en), .sleep_active(slp_act),
    .wake_by_irq(wake_i), .low_freq_oscillator(osc_lf),
    .medium_freq_oscillator(osc_mf), .wdog_reset(wd_rst),
    .violation_flag(viol), .wake_event(wake_ev), .wdog_running(running),
    .irq(irq));

  wwdt_far_model #(.LF_HALF_NS(HALF), .MF_HALF_NS(HALF - 2)) wwdt_far_model_i (
    .mclk(mclk), .wdog_reset(wd_rst), .wake_event(wake_ev), .osc_lf(osc_lf),
    .osc_mf(osc_mf), .n_resets(n_resets), .n_wakes(n_wakes));

  // Clock at 25 MHz
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic end_sim();
    $display("Counts: %0d compares, %0d mismatches", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic hang();
    n_fail++;
    $display("MISMATCH t=%0t wait limit reached", $time);
    end_sim();
  endtask

  // One write; the response code is compared with the one expected
  task automatic wr(input logic [11:0] idx, input logic [7:0] d,
                    input logic [1:0] exp_rs);
    int n;
    n = 0;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge mclk);
      n++;
      if (n > 50) hang();
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        chk(32'(bresp), 32'(exp_rs));
        bready <= 1'b0;
        break;
      end
    end
    @(posedge mclk);
  endtask

  task automatic rd(input logic [11:0] idx, output logic [31:0] d,
                    output logic [1:0] rs);
    int n;
    n = 0;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge mclk);
      n++;
      if (n > 50) hang();
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
    @(posedge mclk);
  endtask

  task automatic rchk(input logic [11:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0]  rs;
    rd(idx, d, rs);
    chk(d, {24'h000000, exp});
    chk(32'(rs), 32'(`WWDT_RESP_OKAY));
  endtask

  // One-cycle pulse: 0 clear, 1 sleep entry, 2 wake by interrupt
  task automatic pulse(input int sel);
    if (sel == 0) clr_i <= 1'b1;
    if (sel == 1) slp_en <= 1'b1;
    if (sel == 2) wake_i <= 1'b1;
    @(posedge mclk);
    clr_i <= 1'b0;
    slp_en <= 1'b0;
    wake_i <= 1'b0;
  endtask

  // Cycles until an output pulse: 0 reset, 1 violation, 2 wake; lim if none
  task automatic wait_ev(input int sel, input int lim, output int n);
    for (n = 0; n < lim; n++) begin
      @(posedge mclk);
      if (sel == 0 && wd_rst === 1'b1) return;
      if (sel == 1 && viol === 1'b1) return;
      if (sel == 2 && wake_ev === 1'b1) return;
    end
  endtask

  // Clock cycles of one interval: 32 steps of 2^code source ticks each
  function automatic int per(input int c);
    return (32 << c) * 2 * HALF / 40;
  endfunction

  task automatic tmo(input logic [4:0] code, input int exp_c);
    wr(`WWDT_IDX_CTRL0, {2'b00, code, 1'b1}, `WWDT_RESP_OKAY);
    chk(32'(running), 32'h1);
    wait_ev(0, 2 * exp_c, cyc);
    chk(32'(cyc >= exp_c * 95 / 100 && cyc <= exp_c * 105 / 100), 32'h1);
  endtask

  task automatic poll_win(input logic [4:0] t);
    logic [31:0] d;
    logic [1:0]  rs;
    for (int i = 0; i < 3000; i++) begin
      rd(`WWDT_IDX_TMR, d, rs);
      if (d[7:3] === t) return;
    end
    hang();
  endtask

  // Main sequence
  initial begin
    n_fail = 0;
    compares = 0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {clr_i, slp_en, slp_act, wake_i} = 4'h0;
    awaddr = 14'h0000;
    araddr = 14'h0000;
    wdata = 32'h00000000;
    cfg_mode = `WWDT_MODE_SOFT;
    cfg_ps = `WWDT_PS_OPEN;
    cfg_cs = `WWDT_CS_OPEN;
    cfg_win = 3'h3;
    sys_rst = 1'b1;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
    rchk(`WWDT_IDX_CTRL0, 8'h16);
    rchk(`WWDT_IDX_CTRL1, 8'h03);
    for (int i = 0; i < 3; i++) rchk(12'hECF + 12'(i), 8'h00);
    rd(12'hECC, v, r);
    chk(v, 32'h00000000);
    chk(32'(r), 32'(`WWDT_RESP_SLVERR));
    chk(32'(running), 32'h0);
    $display("test reset values done");
    wr(`WWDT_IDX_INTMSK, 8'h07, `WWDT_RESP_OKAY);
    tmo(5'h00, per(0));
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'h1);
    rchk(`WWDT_IDX_INTST, 8'h01);
    chk(32'(irq), 32'h0);
    tmo(5'h13, per(0));
    tmo(5'h01, per(1));
    $display("test time-out intervals done");
    wr(`WWDT_IDX_CTRL0, 8'h00, `WWDT_RESP_OKAY);
    chk(32'(running), 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(12'hECF + 12'(i), 8'hFF, `WWDT_RESP_OKAY);
      rchk(12'hECF + 12'(i), 8'h00);
    end
    wr(`WWDT_IDX_CTRL1, 8'h17, `WWDT_RESP_OKAY);
    rchk(`WWDT_IDX_CTRL1, 8'h13);
    $display("test register access done");
    // Code 3 keeps each window step far longer than the bus round trips
    wr(`WWDT_IDX_INTMSK, 8'h00, `WWDT_RESP_OKAY);
    rd(`WWDT_IDX_INTST, v, r);
    wr(`WWDT_IDX_CTRL0, 8'h07, `WWDT_RESP_OKAY);
    pulse(0);
    wait_ev(1, 20, cyc);
    chk(32'(cyc < 20), 32'h1);
    poll_win(5'h0F);
    rd(`WWDT_IDX_CTRL0, v, r);
    rd(`WWDT_IDX_TMR, v, r);
    chk(32'(v[2]), 32'h1);
    pulse(0);
    wait_ev(1, 20, cyc);
    chk(32'(cyc < 20), 32'h1);
    chk(32'(irq), 32'h0);
    poll_win(5'h10);
    rd(`WWDT_IDX_CTRL0, v, r);
    pulse(0);
    wait_ev(1, 20, cyc);
    chk(32'(cyc), 32'h14);
    rd(`WWDT_IDX_TMR, v, r);
    chk(32'(v[7:2]), 32'h0);
    $display("test window done");
    base = n_resets;
    slp_act <= 1'b1;
    pulse(1);
    wait_ev(2, 2 * per(3), cyc);
    chk(32'(cyc < 2 * per(3)), 32'h1);
    chk(n_resets, base);
    slp_act <= 1'b0;
    pulse(2);
    chk(n_wakes, 32'h1);
    $display("test sleep wake done");
    cfg_ps <= 5'h04;
    cfg_cs <= 3'h2;
    sys_rst <= 1'b1;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
    rchk(`WWDT_IDX_CTRL0, 8'h08);
    wr(`WWDT_IDX_CTRL0, 8'h15, `WWDT_RESP_OKAY);
    rchk(`WWDT_IDX_CTRL0, 8'h09);
    wr(`WWDT_IDX_CTRL1, 8'h07, `WWDT_RESP_OKAY);
    rchk(`WWDT_IDX_CTRL1, 8'h23);
    $display("test locked fields done");
    end_sim();
  end
endmodule // windowed_watchdog_regs_counter_test
`default_nettype wire
